// file: include/mpms_defs.svh
// Constants of the power-mode and conversion sequencer.
// Assumes a 20 MHz system clock; included by the tick generator, sequencer, monitor and bench.
`ifndef MPMS_DEFS_SVH
`define MPMS_DEFS_SVH
// Register byte offsets
`define MPMS_OFS_PWR_CMD      8'h00
`define MPMS_OFS_TRIM_CMD     8'h04
`define MPMS_OFS_RATE_AVG     8'h08
`define MPMS_OFS_AXIS_EN      8'h0C
`define MPMS_OFS_STATUS       8'h10
`define MPMS_OFS_DATA_X       8'h14
`define MPMS_OFS_DATA_Y       8'h18
`define MPMS_OFS_DATA_Z       8'h1C
`define MPMS_OFS_DATA_T       8'h20
`define MPMS_OFS_SENS_TIME    8'h24
`define MPMS_OFS_TRIM_ADDR    8'h28
`define MPMS_OFS_TRIM_DATA    8'h2C
// Command codes
`define MPMS_CMD_SUSPEND      8'h00
`define MPMS_CMD_NORMAL       8'h01
`define MPMS_CMD_SLOW_FORCED  8'h03
`define MPMS_CMD_FAST_FORCED  8'h04
`define MPMS_CMD_BOOT_END     8'h80
// Field positions
`define MPMS_RA_AVG_LSB       4
`define MPMS_ST_DRDY_BIT      0
`define MPMS_ST_MODE_LSB      1
`define MPMS_ST_LOCK_BIT      3
`define MPMS_ST_BOOT_BIT      4
// Reset values
`define MPMS_RATE_AVG_RST     8'h04
`define MPMS_AXIS_EN_RST      3'h7
// Timing: clock, sensor-time tick, boot and per-sample times
`define MPMS_CLK_HZ           20000000
`define MPMS_TICK_US          40
`define MPMS_TICK_CYC         ((`MPMS_CLK_HZ / 1000000) * `MPMS_TICK_US)
`define MPMS_BOOT_TICKS       16'd25
`define MPMS_FAST_SMP_TICKS   16'd25
`define MPMS_SLOW_SMP_TICKS   16'd90
`define MPMS_FIRST_EXTRA      16'd50
`endif

// file: include/mpms_pkg.sv
// Types shared by the sequencer modules.
// Assumes mpms_defs.svh for numeric constants.
package mpms_pkg;
  typedef enum logic [2:0] {
    MPMS_OFF, MPMS_BOOT, MPMS_SUSPEND, MPMS_NORMAL, MPMS_FORCED
  } mpms_mode_e;
  typedef logic [23:0] mpms_word_t;
endpackage

// file: rtl/mpms_trim_mem.sv
// Small trim storage, registered read data.
// Assumes the caller gates writes and reads.
module mpms_trim_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  // Clock
  input wire logic clock_i,
  // Access
  input wire logic wr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Write port and registered read
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[addr_i];
  end
endmodule

// file: rtl/mpms_tick_gen.sv
// Sensor-time base: 40 us strobe and a free 24-bit counter.
// Assumes a synchronous active-low reset.
`include "mpms_defs.svh"
module mpms_tick_gen #(
  parameter int TICK_CYC = `MPMS_TICK_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Outputs
  output logic tick_o,
  output logic [23:0] time_o
);
  logic [15:0] div;
  logic [15:0] next_div;
  logic next_tick;
  logic [23:0] next_time;

  // Divider and wrapping counter
  always_comb begin
    next_tick = 1'b0;
    next_div = div + 16'h0001;
    next_time = time_o;
    if (div == 16'(TICK_CYC - 1)) begin
      next_div = 16'h0000;
      next_tick = 1'b1;
      next_time = time_o + 24'h00_0001; // R2
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      div <= 16'h0000;
      tick_o <= 1'b0;
      time_o <= 24'h00_0000;
    end else begin
      div <= next_div;
      tick_o <= next_tick;
      time_o <= next_time;
    end
  end
endmodule

// file: rtl/mpms_sequencer.sv
// Power-mode and conversion sequencer with Avalon-MM register slave.
// Assumes synchronous inputs on clock_i, supply-good levels, raw samples.
//
// Contract
// R1: Axis and temperature results are 21-bit signed in 24-bit registers.
// R2: 24-bit sensor time counts in 40 us steps.
// R3: After boot the block enters suspend on its own.
// R4: Host ends boot by writing 0x80 to the trim command register.
// R5: After boot end, trim storage is blocked until the next boot.
// R6: Stay off while any supply is bad; boot once both good.
// R7: Suspend halts conversions, keeps settings, allows all register access.
// R8: Suspend entered by host command or after a forced conversion.
// R9: Normal mode converts periodically at the selected data rate.
// R10: Average 1, 2, 4 or 8 samples per result by averaging code.
// R11: Host picks only permitted rate and averaging pairs.
// R12: Forced command 0x03 or 0x04 from suspend converts enabled axes once.
// R13: Host uses fast forced at 25 Hz and above, slow below.
// R14: First trigger after long idle uses the slow forced command.
// R15: Forced conversion ends within 5 ms fast single, 30 ms slow eight.
// R16: Durations and periods derive from the internal time base.
// R17: Every accepted forced trigger also converts temperature.
// R18: Forced request during forced or normal mode is ignored.
// R19: Host limits trigger rate by averaging setting.
// R20: Each written result raises data ready as status bit and pin.
// R21: New data is signalled on a dedicated interrupt pin.
// R22: A magnetic reset pulse issues on every data rate tick.
// R23: Current power mode is readable in status.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`include "mpms_defs.svh"
module mpms_sequencer
  import mpms_pkg::*;
#(
  parameter int TRIM_DEPTH = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Supplies and soft reset
  input wire logic core_supply_ok_i,
  input wire logic io_supply_ok_i,
  input wire logic soft_reset_i,
  // Raw transducer samples
  input wire logic [20:0] raw_x_i,
  input wire logic [20:0] raw_y_i,
  input wire logic [20:0] raw_z_i,
  input wire logic [20:0] raw_t_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Events
  output logic data_ready_int_o,
  output logic mag_reset_o
);
  mpms_mode_e mode, next_mode;
  logic [7:0] rate_avg, next_rate_avg;
  logic [2:0] axis_en, next_axis_en;
  logic locked, next_locked;
  logic drdy, next_drdy;
  logic [23:0] data_x, data_y, data_z, data_t, data_time;
  logic [23:0] next_data_x, next_data_y, next_data_z, next_data_t, next_data_time;
  logic [23:0] acc_x, acc_y, acc_z, acc_t;
  logic [23:0] next_acc_x, next_acc_y, next_acc_z, next_acc_t;
  logic [15:0] tcnt, next_tcnt;
  logic [15:0] odr_cnt, next_odr_cnt;
  logic [3:0] smp, next_smp;
  logic busy, next_busy;
  logic fast, next_fast;
  logic first, next_first;
  logic t_en, next_t_en;
  logic ack, next_ack;
  logic waitreq, next_waitreq;
  logic [31:0] rdata, next_rdata;
  logic int_q, next_int_q;
  logic mrst, next_mrst;
  logic tick;
  logic [23:0] stime;
  logic [7:0] trim_rd;
  logic trim_we;
  logic wr_acc, rd_acc;
  logic [7:0] wcmd;
  logic [3:0] nsmp;
  logic [15:0] smp_ticks, odr_ticks;

  // Sign-extended sum helper
  function automatic logic [23:0] sx(input logic [20:0] v);
    return {{3{v[20]}}, v};
  endfunction

  // Arithmetic shift divide by sample count
  function automatic logic [23:0] avg_div(input logic [23:0] s, input logic [1:0] c);
    logic [23:0] r;
    r = 24'($signed(s) >>> c);
    return {{3{r[20]}}, r[20:0]}; // R1
  endfunction

  mpms_tick_gen u_tick (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .tick_o(tick),
    .time_o(stime)
  );

  // Trim storage writable only before boot end
  assign trim_we = wr_acc && (avs_address_i == `MPMS_OFS_TRIM_DATA) && !locked; // R5
  mpms_trim_mem #(.DEPTH(TRIM_DEPTH), .WIDTH(8)) u_trim (
    .clock_i(clock_i),
    .wr_en_i(trim_we),
    .addr_i('0), // Single-address store
    .wr_data_i(avs_writedata_i[7:0]),
    .rd_data_o(trim_rd)
  );

  // Bus strobes: one wait cycle, then ack
  assign wr_acc = avs_write_i && !ack;
  assign rd_acc = avs_read_i && !ack;
  assign wcmd = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
  assign nsmp = 4'h1 << rate_avg[`MPMS_RA_AVG_LSB +: 2]; // R10
  assign smp_ticks = fast ? `MPMS_FAST_SMP_TICKS : `MPMS_SLOW_SMP_TICKS; // R16
  // Data rate period in ticks: 62 << code, code 0 = 400 Hz
  assign odr_ticks = 16'(16'd62 << rate_avg[3:0]); // R9

  // Mode, conversion and register next state
  always_comb begin
    next_mode = mode;
    next_rate_avg = rate_avg;
    next_axis_en = axis_en;
    next_locked = locked;
    next_drdy = drdy;
    next_data_x = data_x;
    next_data_y = data_y;
    next_data_z = data_z;
    next_data_t = data_t;
    next_data_time = data_time;
    next_acc_x = acc_x;
    next_acc_y = acc_y;
    next_acc_z = acc_z;
    next_acc_t = acc_t;
    next_tcnt = tcnt;
    next_odr_cnt = odr_cnt;
    next_smp = smp;
    next_busy = busy;
    next_fast = fast;
    next_first = first;
    next_t_en = t_en;
    next_mrst = 1'b0;
    next_int_q = 1'b0;
    next_ack = (avs_read_i || avs_write_i) && !ack;
    next_waitreq = !next_ack; // Registered so the pin comes from a flop
    next_rdata = rdata;
    // Conversion engine, paced by time base
    if (busy && tick) begin
      if (tcnt != 16'h0000) begin
        next_tcnt = tcnt - 16'h0001;
      end else begin
        next_acc_x = acc_x + sx(raw_x_i);
        next_acc_y = acc_y + sx(raw_y_i);
        next_acc_z = acc_z + sx(raw_z_i);
        next_acc_t = acc_t + sx(raw_t_i);
        next_smp = smp + 4'h1;
        next_tcnt = smp_ticks;
        if (smp + 4'h1 == nsmp) begin
          if (axis_en[0]) next_data_x = avg_div(next_acc_x, rate_avg[5:4]); // R12
          if (axis_en[1]) next_data_y = avg_div(next_acc_y, rate_avg[5:4]);
          if (axis_en[2]) next_data_z = avg_div(next_acc_z, rate_avg[5:4]);
          if (t_en) next_data_t = avg_div(next_acc_t, rate_avg[5:4]); // R17
          next_data_time = stime;
          next_drdy = 1'b1; // R20
          next_int_q = 1'b1; // R21
          next_busy = 1'b0;
          next_first = 1'b0;
          if (mode == MPMS_FORCED) next_mode = MPMS_SUSPEND; // R8
        end
      end
    end
    // Power sequence
    case (mode)
      MPMS_OFF: begin
        if (core_supply_ok_i && io_supply_ok_i) begin // R6
          next_mode = MPMS_BOOT;
          next_tcnt = `MPMS_BOOT_TICKS;
        end
      end
      MPMS_BOOT: begin
        if (tick) begin
          if (tcnt == 16'h0000) begin
            next_mode = MPMS_SUSPEND; // R3
            next_mrst = 1'b1;
            next_first = 1'b1;
          end else begin
            next_tcnt = tcnt - 16'h0001;
          end
        end
      end
      MPMS_NORMAL: begin
        if (tick) begin
          if (odr_cnt == 16'h0000) begin
            next_odr_cnt = odr_ticks - 16'h0001;
            next_mrst = 1'b1; // R22
            if (!busy) begin
              next_busy = 1'b1; // R9
              next_fast = 1'b1;
              next_t_en = 1'b1;
              next_smp = 4'h0;
              next_tcnt = 16'h0000;
              next_acc_x = 24'h00_0000;
              next_acc_y = 24'h00_0000;
              next_acc_z = 24'h00_0000;
              next_acc_t = 24'h00_0000;
            end
          end else begin
            next_odr_cnt = odr_cnt - 16'h0001;
          end
        end
      end
      MPMS_SUSPEND, MPMS_FORCED: begin
      end
      default: next_mode = MPMS_OFF;
    endcase
    // Register writes
    if (wr_acc) begin
      case (avs_address_i)
        `MPMS_OFS_PWR_CMD: begin
          if (wcmd == `MPMS_CMD_SUSPEND && mode != MPMS_BOOT && mode != MPMS_OFF) begin
            next_mode = MPMS_SUSPEND; // R8
            next_busy = 1'b0;
          end else if (wcmd == `MPMS_CMD_NORMAL && mode == MPMS_SUSPEND) begin
            next_mode = MPMS_NORMAL;
            next_odr_cnt = 16'h0000;
          end else if ((wcmd == `MPMS_CMD_SLOW_FORCED || wcmd == `MPMS_CMD_FAST_FORCED)
                       && mode == MPMS_SUSPEND && !busy) begin // R18
            next_mode = MPMS_FORCED; // R12
            next_busy = 1'b1;
            next_fast = (wcmd == `MPMS_CMD_FAST_FORCED);
            next_t_en = 1'b1; // R17
            next_smp = 4'h0;
            next_mrst = 1'b1; // R22
            // First sample after boot takes extra settling
            next_tcnt = first ? `MPMS_FIRST_EXTRA : 16'h0000; // R15
            next_acc_x = 24'h00_0000;
            next_acc_y = 24'h00_0000;
            next_acc_z = 24'h00_0000;
            next_acc_t = 24'h00_0000;
          end
        end
        `MPMS_OFS_TRIM_CMD: begin
          if (wcmd == `MPMS_CMD_BOOT_END) next_locked = 1'b1; // R4
        end
        `MPMS_OFS_RATE_AVG: if (avs_byteenable_i[0]) next_rate_avg = avs_writedata_i[7:0];
        `MPMS_OFS_AXIS_EN: if (avs_byteenable_i[0]) next_axis_en = avs_writedata_i[2:0]; // R7
        default: begin
        end
      endcase
    end
    // Register reads; status read clears data ready unless set now
    if (rd_acc) begin
      case (avs_address_i)
        `MPMS_OFS_RATE_AVG: next_rdata = {24'h00_0000, rate_avg};
        `MPMS_OFS_AXIS_EN: next_rdata = {29'h0000_0000, axis_en};
        `MPMS_OFS_STATUS: begin
          next_rdata = {27'h000_0000, (mode == MPMS_BOOT), locked,
                        (mode == MPMS_NORMAL), (mode == MPMS_FORCED), drdy}; // R23
          if (!next_int_q) next_drdy = 1'b0;
        end
        `MPMS_OFS_DATA_X: next_rdata = {8'h00, data_x}; // R1
        `MPMS_OFS_DATA_Y: next_rdata = {8'h00, data_y};
        `MPMS_OFS_DATA_Z: next_rdata = {8'h00, data_z};
        `MPMS_OFS_DATA_T: next_rdata = {8'h00, data_t};
        `MPMS_OFS_SENS_TIME: next_rdata = {8'h00, data_time}; // R2
        `MPMS_OFS_TRIM_DATA: next_rdata = locked ? 32'h0000_0000 : {24'h00_0000, trim_rd}; // R5
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    // Supply loss or soft reset restarts from off
    if (!(core_supply_ok_i && io_supply_ok_i) || soft_reset_i) begin // R6
      next_mode = MPMS_OFF;
      next_locked = 1'b0;
      next_busy = 1'b0;
      next_drdy = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      mode <= MPMS_OFF;
      rate_avg <= `MPMS_RATE_AVG_RST;
      axis_en <= `MPMS_AXIS_EN_RST;
      locked <= 1'b0;
      drdy <= 1'b0;
      data_x <= 24'h00_0000;
      data_y <= 24'h00_0000;
      data_z <= 24'h00_0000;
      data_t <= 24'h00_0000;
      data_time <= 24'h00_0000;
      acc_x <= 24'h00_0000;
      acc_y <= 24'h00_0000;
      acc_z <= 24'h00_0000;
      acc_t <= 24'h00_0000;
      tcnt <= 16'h0000;
      odr_cnt <= 16'h0000;
      smp <= 4'h0;
      busy <= 1'b0;
      fast <= 1'b0;
      first <= 1'b1;
      t_en <= 1'b0;
      ack <= 1'b0;
      waitreq <= 1'b1;
      rdata <= 32'h0000_0000;
      int_q <= 1'b0;
      mrst <= 1'b0;
    end else begin
      mode <= next_mode;
      rate_avg <= next_rate_avg;
      axis_en <= next_axis_en;
      locked <= next_locked;
      drdy <= next_drdy;
      data_x <= next_data_x;
      data_y <= next_data_y;
      data_z <= next_data_z;
      data_t <= next_data_t;
      data_time <= next_data_time;
      acc_x <= next_acc_x;
      acc_y <= next_acc_y;
      acc_z <= next_acc_z;
      acc_t <= next_acc_t;
      tcnt <= next_tcnt;
      odr_cnt <= next_odr_cnt;
      smp <= next_smp;
      busy <= next_busy;
      fast <= next_fast;
      first <= next_first;
      t_en <= next_t_en;
      ack <= next_ack;
      waitreq <= next_waitreq;
      rdata <= next_rdata;
      int_q <= next_int_q;
      mrst <= next_mrst;
    end
  end

  // Registered outputs
  assign avs_readdata_o = rdata;
  assign avs_waitrequest_o = waitreq;
  assign data_ready_int_o = int_q;
  assign mag_reset_o = mrst;
endmodule

// file: verification/mpms_sequencer_monitor.sv
// Checker for the sequencer register port and event pins.
// Assumes it is bound to mpms_sequencer and sees only its ports.
`include "mpms_defs.svh"
module mpms_sequencer_monitor (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Supplies and soft reset
  input wire logic core_supply_ok_i,
  input wire logic io_supply_ok_i,
  input wire logic soft_reset_i,
  // Register port
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Events
  input wire logic data_ready_int_o,
  input wire logic mag_reset_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Steps of one transfer
  sequence s_req_new;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence s_ack_rd;
    avs_read_i && !avs_waitrequest_o;
  endsequence
  sequence s_boot_end;
    avs_write_i && !avs_waitrequest_o && avs_address_i == `MPMS_OFS_TRIM_CMD
      && avs_byteenable_i[0] && avs_writedata_i[7:0] == `MPMS_CMD_BOOT_END;
  endsequence
  sequence s_trim_rd;
    avs_read_i && !avs_waitrequest_o && avs_address_i == `MPMS_OFS_TRIM_DATA;
  endsequence
  // Handshake shape
  property p_ack_next;
    s_req_new |=> !avs_waitrequest_o;
  endproperty
  property p_ack_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  property p_ack_req;
    !avs_waitrequest_o |-> (avs_read_i || avs_write_i);
  endproperty
  property p_rd_hold;
    !avs_read_i |=> $stable(avs_readdata_o);
  endproperty
  // Read contents
  property p_upper_zero;
    s_ack_rd |-> avs_readdata_o[31:24] == 8'h00;
  endproperty
  property p_unmapped;
    s_ack_rd ##0 (avs_address_i > `MPMS_OFS_TRIM_DATA) |-> avs_readdata_o == 32'h0000_0000;
  endproperty
  // Event pulses
  property p_int_pulse;
    data_ready_int_o |=> !data_ready_int_o;
  endproperty
  property p_mag_pulse;
    mag_reset_o |=> !mag_reset_o;
  endproperty
  // Trim store reads zero within 300 cycles after boot end, unless a new boot starts
  property p_trim_lock;
    disable iff (!reset_n_i || soft_reset_i || !core_supply_ok_i || !io_supply_ok_i)
    s_boot_end ##[1:300] s_trim_rd |-> avs_readdata_o == 32'h0000_0000;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no acknowledge one cycle after request");
  a_ack_one: assert property (p_ack_one)
    else $error("acknowledge longer than one cycle");
  a_ack_req: assert property (p_ack_req)
    else $error("acknowledge without request");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without read");
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper byte not zero");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_int_pulse: assert property (p_int_pulse)
    else $error("data ready longer than one cycle");
  a_mag_pulse: assert property (p_mag_pulse)
    else $error("magnetic reset longer than one cycle");
  a_trim_lock: assert property (p_trim_lock)
    else $error("trim store readable after boot end");
endmodule
bind mpms_sequencer mpms_sequencer_monitor u_mon (
  .clock_i,
  .reset_n_i,
  .core_supply_ok_i,
  .io_supply_ok_i,
  .soft_reset_i,
  .avs_address_i,
  .avs_read_i,
  .avs_write_i,
  .avs_writedata_i,
  .avs_byteenable_i,
  .avs_readdata_o,
  .avs_waitrequest_o,
  .data_ready_int_o,
  .mag_reset_o
);

// file: verification/mpms_sensor_model.sv
// Front-end stand-in: supply monitors and fixed raw samples.
// Assumes the bench switches each rail; a steady field is applied.
module mpms_sensor_model #(
  parameter int RAMP = 20
) (
  // Clock and rail switches
  input wire logic clock_i,
  input wire logic core_en_i,
  input wire logic io_en_i,
  // Supply good and samples
  output logic core_ok_o,
  output logic io_ok_o,
  output logic [20:0] raw_x_o,
  output logic [20:0] raw_y_o,
  output logic [20:0] raw_z_o,
  output logic [20:0] raw_t_o
);
  int core_cnt = 0;
  int io_cnt = 0;
  // Rail ramp counters, cleared at once when a rail drops
  always @(posedge clock_i) begin
    core_cnt <= core_en_i ? core_cnt + 1 : 0;
    io_cnt <= io_en_i ? io_cnt + 1 : 0;
  end
  // Good only once ramped
  assign core_ok_o = core_en_i && core_cnt >= RAMP;
  assign io_ok_o = io_en_i && io_cnt >= RAMP;
  // Steady field and die temperature
  assign raw_x_o = 21'h0_1234;
  assign raw_y_o = 21'h0_0567;
  assign raw_z_o = 21'h0_0abc;
  assign raw_t_o = 21'h0_0042;
endmodule

// file: verification/mpms_sequencer_tb_top.sv
// Bench for the sequencer: register tests over the Avalon port.
// Assumes the front-end model supplies rails and fixed samples.
`include "mpms_defs.svh"
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module mpms_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ST = `MPMS_OFS_STATUS;
  localparam logic [7:0] PW = `MPMS_OFS_PWR_CMD;
  localparam logic [7:0] RA = `MPMS_OFS_RATE_AVG;
  localparam logic [7:0] AX = `MPMS_OFS_AXIS_EN;
  localparam logic [7:0] TD = `MPMS_OFS_TRIM_DATA;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic core_en = 1'b0;
  logic io_en = 1'b1;
  logic soft_reset_i = 1'b0;
  logic core_ok;
  logic io_ok;
  logic [20:0] raw_x;
  logic [20:0] raw_y;
  logic [20:0] raw_z;
  logic [20:0] raw_t;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic data_ready_int_o;
  logic mag_reset_o;
  logic [31:0] q;
  int miscompares = 0;
  int n_compared = 0;
  int n_int = 0;
  int n_mag = 0;
  int base;
  int mbase;
  // Clock
  always #25 clock_i = ~clock_i;
  // Event pulse counters, sampled where settled
  always @(negedge clock_i) begin
    if (data_ready_int_o === 1'b1) n_int++;
    if (mag_reset_o === 1'b1) n_mag++;
  end
  mpms_sensor_model u_fe (
    .clock_i,
    .core_en_i(core_en),
    .io_en_i(io_en),
    .core_ok_o(core_ok),
    .io_ok_o(io_ok),
    .raw_x_o(raw_x),
    .raw_y_o(raw_y),
    .raw_z_o(raw_z),
    .raw_t_o(raw_t)
  );
  mpms_sequencer u_dut (
    .clock_i,
    .reset_n_i,
    .core_supply_ok_i(core_ok),
    .io_supply_ok_i(io_ok),
    .soft_reset_i,
    .raw_x_i(raw_x),
    .raw_y_i(raw_y),
    .raw_z_i(raw_z),
    .raw_t_i(raw_t),
    .avs_address_i,
    .avs_read_i,
    .avs_write_i,
    .avs_writedata_i,
    .avs_byteenable_i(4'hf),
    .avs_readdata_o,
    .avs_waitrequest_o,
    .data_ready_int_o,
    .mag_reset_o
  );
  // One transfer, held until waitrequest is seen low
  // Waitrequest and read data are taken at the rising edge; watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask
  task automatic done(input string s);
    $display("test %0s done", s);
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (95000) @(posedge clock_i);
    miscompares++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (100) @(posedge clock_i);
    rd(ST, 32'h0000_0000);
    core_en <= 1'b1;
    repeat (30) @(posedge clock_i);
    rd(ST, 32'h0000_0010);
    repeat (22000) @(posedge clock_i);
    rd(ST, 32'h0000_0000);
    done("boot");
    rd(RA, 32'h0000_0004);
    rd(AX, 32'h0000_0007);
    wr(RA, 32'h0000_0022);
    rd(RA, 32'h0000_0022);
    wr(RA, 32'h0000_0004);
    wr(AX, 32'h0000_0005);
    rd(AX, 32'h0000_0005);
    rd(8'hf0, 32'h0000_0000);
    done("regs");
    wr(TD, 32'h0000_00a5);
    rd(TD, 32'h0000_00a5);
    wr(`MPMS_OFS_TRIM_CMD, 32'h0000_0080);
    rd(ST, 32'h0000_0008);
    rd(TD, 32'h0000_0000);
    done("trim");
    wr(PW, 32'h0000_0001);
    rd(ST, 32'h0000_000c);
    wr(PW, 32'h0000_0004);
    rd(ST, 32'h0000_000c);
    wr(PW, 32'h0000_0000);
    rd(ST, 32'h0000_0008);
    done("normal");
    base = n_int;
    mbase = n_mag;
    wr(PW, 32'h0000_0004);
    wr(PW, 32'h0000_0003);
    rd(ST, 32'h0000_000a);
    for (int n = 0; n < 62000 && n_int == base; n++) begin
      @(posedge clock_i);
    end
    `CHK(n_int, base + 1)
    `CHK(n_mag, mbase + 1)
    rd(ST, 32'h0000_0009);
    rd(ST, 32'h0000_0008);
    rd(`MPMS_OFS_DATA_X, {11'h000, raw_x});
    rd(`MPMS_OFS_DATA_Y, 32'h0000_0000);
    rd(`MPMS_OFS_DATA_Z, {11'h000, raw_z});
    rd(`MPMS_OFS_DATA_T, {11'h000, raw_t});
    // Slow forced trigger, single sample, settled front end
    base = n_int;
    wr(PW, 32'h0000_0003);
    for (int n = 0; n < 2000 && n_int == base; n++) begin
      @(posedge clock_i);
    end
    `CHK(n_int, base + 1)
    rd(ST, 32'h0000_0009);
    done("forced");
    soft_reset_i <= 1'b1;
    @(posedge clock_i);
    soft_reset_i <= 1'b0;
    rd(ST, 32'h0000_0010);
    io_en <= 1'b0;
    repeat (5) @(posedge clock_i);
    rd(ST, 32'h0000_0000);
    done("power");
    stop_test();
  end
endmodule
